// ---- logic/acd_decoder.v ----
// Serial command decoder and frame shifter of the eight-channel converter.
`timescale 1ns/1ps
`include "acd_regs.vh"
module acd_decoder #(
    parameter CLK_HZ = 200000000,
    parameter MCLK_DIV = 98,
    parameter TRIM_CYCLES = 30600000,
    parameter REG_DEPTH = 32
) (
    clk,
    rst_n,
    cs_n,
    sclk,
    din,
    start_pin,
    conv_done,
    frame_data,
    wide_words,
    dout,
    sample_ready_n,
    standby,
    converting,
    continuous,
    trim_busy,
    rate_select,
    reg_wr_valid,
    reg_wr_addr,
    reg_wr_data,
    reg_wr_ready,
    busy
);
    input wire clk;
    input wire rst_n;
    input wire cs_n;
    input wire sclk;
    input wire din;
    input wire start_pin;
    input wire conv_done;
    input wire [215:0] frame_data;
    input wire wide_words;
    output reg dout;
    output reg sample_ready_n;
    output reg standby;
    output reg converting;
    output reg continuous;
    output reg trim_busy;
    output reg [2:0] rate_select;
    output reg reg_wr_valid;
    output reg [4:0] reg_wr_addr;
    output reg [7:0] reg_wr_data;
    input wire reg_wr_ready;
    output reg busy;

    localparam FRAME_W = 216;
    localparam WAIT_DEC = `ACD_DECODE_MCLK * MCLK_DIV;
    localparam WAIT_RST = `ACD_RESET_MCLK * MCLK_DIV;
    localparam S_CMD = 4'b0001;
    localparam S_CNT = 4'b0010;
    localparam S_WDAT = 4'b0100;
    localparam S_RDAT = 4'b1000;

    // Three-flop chains for the pins; the second stage is read, and the third also for the clock edges.
    reg [2:0] cs_s_q, sclk_s_q, din_s_q;
    always @(posedge clk) begin
        cs_s_q <= {cs_s_q[1:0], cs_n};
        sclk_s_q <= {sclk_s_q[1:0], sclk};
        din_s_q <= {din_s_q[1:0], din};
    end
    wire cs_lo = ~cs_s_q[1];
    wire sclk_rise = sclk_s_q[1] & ~sclk_s_q[2];
    wire sclk_fall = ~sclk_s_q[1] & sclk_s_q[2];
    wire din_b = din_s_q[1];

    reg [3:0] state_q;
    reg [2:0] bit_q;
    reg [7:0] sh_q;
    reg [7:0] byte_q;
    reg [2:0] op_q;
    reg [4:0] addr_q;
    reg [4:0] cnt_q;
    reg [31:0] wait_q;
    reg [31:0] trim_q;
    reg [FRAME_W-1:0] out_q;
    reg conv_done_q;
    reg stop_pend_q;
    reg fetch_q;
    reg [7:0] regs_q [0:REG_DEPTH-1];

    // Two-entry buffer for written register bytes; a byte arriving while both entries are full is dropped.
    reg [7:0] buf_d0_q, buf_d1_q;
    reg [4:0] buf_a0_q, buf_a1_q;
    reg [1:0] buf_n_q;
    wire buf_in_ready = (buf_n_q != 2'd2);
    wire buf_push;
    wire [12:0] buf_in;
    wire buf_pop = reg_wr_valid & reg_wr_ready;
    always @(posedge clk) begin
        if (!rst_n) begin
            buf_n_q <= 2'd0;
            reg_wr_valid <= 1'b0;
            reg_wr_addr <= 5'h00;
            reg_wr_data <= 8'h00;
            buf_d0_q <= 8'h00;
            buf_d1_q <= 8'h00;
            buf_a0_q <= 5'h00;
            buf_a1_q <= 5'h00;
        end else begin
            case ({buf_push, buf_pop})
                2'b10: begin
                    if (buf_n_q == 2'd0) begin
                        buf_a0_q <= buf_in[12:8];
                        buf_d0_q <= buf_in[7:0];
                    end else begin
                        buf_a1_q <= buf_in[12:8];
                        buf_d1_q <= buf_in[7:0];
                    end
                    buf_n_q <= buf_n_q + 2'd1;
                end
                2'b01: begin
                    buf_a0_q <= buf_a1_q;
                    buf_d0_q <= buf_d1_q;
                    buf_n_q <= buf_n_q - 2'd1;
                end
                2'b11: begin
                    if (buf_n_q == 2'd1) begin
                        buf_a0_q <= buf_in[12:8];
                        buf_d0_q <= buf_in[7:0];
                    end else begin
                        buf_a0_q <= buf_a1_q;
                        buf_d0_q <= buf_d1_q;
                        buf_a1_q <= buf_in[12:8];
                        buf_d1_q <= buf_in[7:0];
                    end
                end
                default: begin
                end
            endcase
            // Head of the buffer is registered onto the outputs.
            reg_wr_valid <= (buf_n_q != 2'd0) & ~buf_pop | (buf_n_q == 2'd2) | buf_push;
            reg_wr_addr <= buf_pop ? (buf_n_q == 2'd2 ? buf_a1_q : buf_in[12:8]) : buf_a0_q;
            reg_wr_data <= buf_pop ? (buf_n_q == 2'd2 ? buf_d1_q : buf_in[7:0]) : buf_d0_q;
            if (buf_n_q == 2'd0 && buf_push) begin
                reg_wr_addr <= buf_in[12:8];
                reg_wr_data <= buf_in[7:0];
            end
        end
    end

    // Byte assembly; the seventh fall is the eighth bit minus one.
    wire [7:0] early = {sh_q[6:0], din_b};
    wire fall7 = cs_lo & sclk_fall & (bit_q == 3'd6);
    wire fall8 = cs_lo & sclk_fall & (bit_q == 3'd7);

    // Push is combinational so the buffer and the register file see the same cycle.
    assign buf_push = (state_q == S_WDAT) & fall8 & buf_in_ready;
    assign buf_in = {addr_q, early};

    always @(posedge clk) begin
        if (!rst_n) begin
            state_q <= S_CMD;
            bit_q <= 3'd0;
            sh_q <= 8'h00;
            byte_q <= 8'h00;
            op_q <= 3'd0;
            addr_q <= 5'h00;
            cnt_q <= 5'h00;
            wait_q <= 32'd0;
            trim_q <= 32'd0;
            out_q <= {FRAME_W{1'b0}};
            dout <= 1'b0;
            sample_ready_n <= 1'b1;
            standby <= 1'b0;
            converting <= 1'b0;
            continuous <= 1'b1;
            trim_busy <= 1'b0;
            rate_select <= 3'h4;
            busy <= 1'b0;
            conv_done_q <= 1'b0;
            stop_pend_q <= 1'b0;
            fetch_q <= 1'b0;
        end else begin
            conv_done_q <= conv_done;
            if (wait_q != 32'd0) begin
                wait_q <= wait_q - 32'd1;
            end
            busy <= (wait_q > 32'd1) | trim_busy;
            // Stop takes effect only once the running conversion is done.
            if (conv_done && stop_pend_q) begin
                converting <= 1'b0;
                stop_pend_q <= 1'b0;
            end
            // Ready falls on a new result and loads the frame when continuous.
            if (conv_done && !conv_done_q && (converting | start_pin)) begin
                sample_ready_n <= 1'b0;
                if (continuous) begin
                    out_q <= frame_data;
                    dout <= 1'b0;
                end
            end
            if (sclk_fall) begin
                sample_ready_n <= 1'b1;
            end
            if (trim_busy) begin
                trim_q <= trim_q - 32'd1;
                if (trim_q == 32'd1) begin
                    trim_busy <= 1'b0;
                    rate_select <= regs_q[1][2:0];
                end
            end
            // Output shift on rising edges while selected.
            if (cs_lo && sclk_rise && (continuous | fetch_q)) begin
                dout <= out_q[FRAME_W-1];
                out_q <= {out_q[FRAME_W-2:0], 1'b0};
            end
            if (!cs_lo) begin
                bit_q <= 3'd0;
                fetch_q <= 1'b0;
            end else if (sclk_fall) begin
                bit_q <= bit_q + 3'd1;
                sh_q <= early;
                if (bit_q == 3'd7) begin
                    byte_q <= early;
                end
            end
            // Seventh fall: only seven bits are in, and every opcode here has bit 0 clear.
            if (fall7 && state_q == S_CMD && wait_q == 32'd0 && !trim_busy) begin
                if (standby) begin
                    if ({early[6:0], 1'b0} == `ACD_OP_WAKE) begin
                        standby <= 1'b0;
                        wait_q <= WAIT_DEC;
                        busy <= 1'b1;
                    end
                end else if (!continuous) begin
                    case ({early[6:0], 1'b0})
                        `ACD_OP_STANDBY: standby <= 1'b1;
                        `ACD_OP_RESET: begin
                            wait_q <= WAIT_RST;
                            busy <= 1'b1;
                            converting <= 1'b0;
                            continuous <= 1'b1;
                            rate_select <= 3'h4;
                        end
                        `ACD_OP_START: begin
                            if (!start_pin && !converting) begin
                                converting <= 1'b1;
                            end
                            stop_pend_q <= 1'b0;
                        end
                        `ACD_OP_STOP: begin
                            if (converting) begin
                                stop_pend_q <= 1'b1;
                            end
                        end
                        `ACD_OP_TRIM: begin
                            trim_busy <= 1'b1;
                            rate_select <= `ACD_TRIM_RATE;
                            trim_q <= TRIM_CYCLES;
                        end
                        `ACD_OP_RDATA: begin
                            out_q <= frame_data;
                            fetch_q <= 1'b1;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            // Register commands need the full byte, decoded on the eighth fall.
            case (state_q)
                S_CMD: begin
                    if (fall8 && wait_q == 32'd0 && !standby && !trim_busy) begin
                        // The two readout-mode opcodes differ only in bit 0, so wait for it.
                        if (continuous) begin
                            if (early == `ACD_OP_SDC) begin
                                continuous <= 1'b0;
                                wait_q <= WAIT_DEC;
                                busy <= 1'b1;
                            end
                        end else if (early == `ACD_OP_RDC) begin
                            continuous <= 1'b1;
                            wait_q <= WAIT_DEC;
                            busy <= 1'b1;
                        end else if (early[7:5] == `ACD_OP_FETCH && !continuous) begin
                            op_q <= `ACD_OP_FETCH;
                            addr_q <= early[4:0];
                            state_q <= S_CNT;
                        end else if (early[7:5] == `ACD_OP_STORE && !continuous) begin
                            op_q <= `ACD_OP_STORE;
                            addr_q <= early[4:0];
                            state_q <= S_CNT;
                        end
                    end
                end
                S_CNT: begin
                    if (!cs_lo) begin
                        state_q <= S_CMD;
                    end else if (fall8) begin
                        cnt_q <= early[4:0];
                        if (op_q == `ACD_OP_FETCH) begin
                            out_q <= {regs_q[addr_q], {(FRAME_W-8){1'b0}}};
                            fetch_q <= 1'b1;
                            state_q <= S_RDAT;
                        end else begin
                            state_q <= S_WDAT;
                        end
                    end
                end
                S_WDAT: begin
                    if (!cs_lo) begin
                        state_q <= S_CMD;
                    end else if (fall8 && buf_in_ready) begin
                        addr_q <= addr_q + 5'd1;
                        cnt_q <= cnt_q - 5'd1;
                        if (cnt_q == 5'd0) begin
                            state_q <= S_CMD;
                        end
                    end
                end
                S_RDAT: begin
                    if (!cs_lo) begin
                        state_q <= S_CMD;
                    end else if (fall8) begin
                        addr_q <= addr_q + 5'd1;
                        cnt_q <= cnt_q - 5'd1;
                        out_q <= {regs_q[addr_q + 5'd1], {(FRAME_W-8){1'b0}}};
                        if (cnt_q == 5'd0) begin
                            state_q <= S_CMD;
                        end
                    end
                end
                default: state_q <= S_CMD;
            endcase
        end
    end

    // Shadow register file; only rst_n clears the entries, the reset command leaves them.
    genvar gi;
    generate
        for (gi = 0; gi < REG_DEPTH; gi = gi + 1) begin : g_reg
            always @(posedge clk) begin
                if (!rst_n) begin
                    regs_q[gi] <= 8'h00;
                end else if (buf_push && buf_in[12:8] == gi) begin
                    regs_q[gi] <= buf_in[7:0];
                end
            end
        end
    endgenerate
endmodule

// ---- logic/acd_regs.vh ----
// Constants for the serial command decoder of the eight-channel converter.
// Overview of operation
// - Decode 02h wake, 04h standby, 06h reset.
// - Decode 08h start, 0Ah stop, 1Ah offset trim.
// - Decode 10h continuous, 11h leave, 12h read.
// - Register fetch/store: two bytes, address and count.
// - System commands on seventh, register on eighth edge.
// - Register fetch ignored in continuous mode.
// - Wake then four master clocks before next.
// - In standby only the wake command counts.
// - Reset restores defaults, busy eighteen master clocks.
// - Start begins conversions; if running, it only cancels a pending stop.
// - Stop lets current conversion finish; idempotent.
// - Offset trim: rate 110, sixteen samples, 153 ms.
// - Continuous mode loads frame on each ready fall.
// - Continuous readout is active after power-up.
// - Frame: 24 status bits, eight channel words.
// - In continuous mode, idle select-low output falls with ready.
// - Ready returns high on first serial falling edge.
`ifndef ACD_REGS_VH
`define ACD_REGS_VH
`define ACD_OP_WAKE 8'h02
`define ACD_OP_STANDBY 8'h04
`define ACD_OP_RESET 8'h06
`define ACD_OP_START 8'h08
`define ACD_OP_STOP 8'h0A
`define ACD_OP_TRIM 8'h1A
`define ACD_OP_RDC 8'h10
`define ACD_OP_SDC 8'h11
`define ACD_OP_RDATA 8'h12
`define ACD_OP_FETCH 3'h1
`define ACD_OP_STORE 3'h2
`define ACD_TRIM_RATE 3'h6
`define ACD_TRIM_SAMPLES 5'h10
`define ACD_DECODE_MCLK 4
`define ACD_RESET_MCLK 18
`define ACD_TRIM_MS 153
`define ACD_STATUS_BITS 24
`define ACD_CHANNELS 8
`endif

// ---- test/acd_host.sv ----
// Host serial master model that drives select, clock and data.
`timescale 1ns/1ps
module acd_host (
    input wire logic clk,
    input wire logic dout,
    output logic cs_n,
    output logic sclk,
    output logic din
);
    // Select idles high and the clock stands low between frames.
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
    end
    // A deselected data line must not hold its last value, so it toggles.
    always @(negedge clk) begin
        if (cs_n)
            din = ~din;
    end
    // One byte MSB first at 80 ns per bit; select stays low after it.
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        if (cs_n) begin
            cs_n = 1'b0;
            repeat (4) @(negedge clk);
        end
        for (int i = 7; i >= 0; i--) begin
            din = tx[i];
            sclk = 1'b1;
            repeat (8) @(negedge clk);
            rx[i] = dout;
            sclk = 1'b0;
            repeat (8) @(negedge clk);
        end
    endtask
    // Select goes high only between whole commands.
    task automatic deselect;
        cs_n = 1'b1;
        repeat (8) @(negedge clk);
    endtask
endmodule

// ---- test/acd_checker.sv ----
// Concurrent checks on the decoder ports, bound into each decoder.
`timescale 1ns/1ps
module acd_checker #(
    parameter MCLK_DIV = 98,
    parameter TRIM_CYCLES = 100
) (
    input wire clk,
    input wire rst_n,
    input wire cs_n,
    input wire sclk,
    input wire dout,
    input wire sample_ready_n,
    input wire standby,
    input wire continuous,
    input wire trim_busy,
    input wire [2:0] rate_select,
    input wire reg_wr_valid,
    input wire [4:0] reg_wr_addr,
    input wire [7:0] reg_wr_data,
    input wire reg_wr_ready,
    input wire busy
);
    localparam int BW = 4 * MCLK_DIV;
    localparam int RW = 18 * MCLK_DIV + 4;
    localparam int TL = TRIM_CYCLES - 1;
    int bcnt_q;
    int tcnt_q;
    // Long windows are counted here, since repetitions that long are too slow.
    always @(posedge clk) begin
        bcnt_q <= (!rst_n || !busy) ? 0 : bcnt_q + 1;
        tcnt_q <= (!rst_n || !trim_busy) ? 0 : tcnt_q + 1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_wait_min: assert property ($fell(busy) |-> bcnt_q >= BW)
        else $error("wait window too short");
    chk_wait_max: assert property (busy |-> bcnt_q <= RW)
        else $error("wait window too long");
    chk_trim_len: assert property ($fell(trim_busy) |-> tcnt_q >= TL)
        else $error("trim ended early");
    chk_trim_rate: assert property (trim_busy |-> rate_select == 3'h6)
        else $error("trim rate wrong");
    chk_ready_clear: assert property ($fell(sclk) && !sample_ready_n |-> ##[1:6] sample_ready_n)
        else $error("ready not cleared by clock");
    chk_stby_only: assert property ($rose(trim_busy) |-> !$past(standby))
        else $error("trim accepted in standby");
    chk_cont_only: assert property ($rose(standby) || $rose(trim_busy) |-> !$past(continuous))
        else $error("command accepted in continuous mode");
    chk_buf_hold: assert property (reg_wr_valid && !reg_wr_ready |=>
        reg_wr_valid && $stable(reg_wr_addr) && $stable(reg_wr_data))
        else $error("buffered word lost");
    chk_idle_low: assert property ($fell(sample_ready_n) && !cs_n && !sclk && continuous
        |-> ##[0:2] !dout)
        else $error("idle data not low with ready");
endmodule
bind acd_decoder acd_checker #(.MCLK_DIV(MCLK_DIV), .TRIM_CYCLES(TRIM_CYCLES)) acd_checker_i (
    .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .dout(dout),
    .sample_ready_n(sample_ready_n), .standby(standby), .continuous(continuous),
    .trim_busy(trim_busy), .rate_select(rate_select), .reg_wr_valid(reg_wr_valid),
    .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data), .reg_wr_ready(reg_wr_ready),
    .busy(busy));

// ---- test/acd_decoder_bench.sv ----
// Self-checking bench for the decoder, driven by the host model.
`timescale 1ns/1ps
module acd_decoder_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic start_pin = 1'b0;
    logic conv_done = 1'b0;
    logic reg_wr_ready = 1'b0;
    logic [215:0] frame_data;
    logic [7:0] win_q;
    wire cs_n, sclk, din, dout, sample_ready_n, standby, converting, continuous;
    wire trim_busy, reg_wr_valid, busy;
    wire [2:0] rate_select;
    wire [4:0] reg_wr_addr;
    wire [7:0] reg_wr_data;
    wire [7:0] flags = {4'h0, standby, converting, continuous, trim_busy};
    int err_count = 0;
    int samples_checked = 0;
    acd_decoder #(.MCLK_DIV(8), .TRIM_CYCLES(100)) acd_decoder_i (
        .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .din(din),
        .start_pin(start_pin), .conv_done(conv_done), .frame_data(frame_data),
        .wide_words(1'b0), .dout(dout), .sample_ready_n(sample_ready_n),
        .standby(standby), .converting(converting), .continuous(continuous),
        .trim_busy(trim_busy), .rate_select(rate_select), .reg_wr_valid(reg_wr_valid),
        .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data),
        .reg_wr_ready(reg_wr_ready), .busy(busy));
    acd_host acd_host_i (.clk(clk), .dout(dout), .cs_n(cs_n), .sclk(sclk), .din(din));
    // A 5 ns clock.
    initial begin
        forever #2.5 clk = ~clk;
    end
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        if (err_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // One byte, a snapshot of the wait window, then the wait is sat out.
    task automatic xb(input logic [7:0] b);
        logic [7:0] r;
        acd_host_i.xfer(b, r);
        win_q = {busy, trim_busy, 3'h0, rate_select};
        for (int i = 0; i < 2000 && (busy !== 1'b0 || trim_busy !== 1'b0); i++) @(negedge clk);
    endtask
    task automatic cmd(input logic [7:0] b);
        xb(b);
        acd_host_i.deselect;
    endtask
    // A finished conversion; the pulse is wide enough to be seen.
    task automatic pulse;
        conv_done = 1'b1;
        repeat (2) @(negedge clk);
        conv_done = 1'b0;
        repeat (8) @(negedge clk);
    endtask
    task automatic t_frame;
        logic [7:0] r;
        start_pin = 1'b1;
        pulse;
        cmp({7'h0, sample_ready_n}, 8'h00);
        cmp({7'h0, dout}, 8'h00);
        for (int i = 26; i >= 0; i--) begin
            acd_host_i.xfer(8'h00, r);
            cmp(r, frame_data[8*i +: 8]);
        end
        acd_host_i.deselect;
        start_pin = 1'b0;
        pulse;
        pulse;
    endtask
    task automatic t_store(input logic want);
        xb(8'h43);
        xb(8'h01);
        xb(8'hAA);
        xb(8'h55);
        acd_host_i.deselect;
        for (int i = 0; want && i < 2; i++) begin
            cmp({reg_wr_valid, 2'h0, reg_wr_addr}, 8'h83 + 8'(i));
            cmp(reg_wr_data, i ? 8'h55 : 8'hAA);
            reg_wr_ready = 1'b1;
            @(negedge clk);
            reg_wr_ready = 1'b0;
            @(negedge clk);
        end
        cmp({7'h0, reg_wr_valid}, 8'h00);
    endtask
    task automatic t_leave;
        cmd(8'h04);
        cmp(flags, 8'h02);
        cmd(8'h11);
        cmp(flags, 8'h00);
        cmd(8'hFF);
        cmd(8'h00);
        cmd(8'h12);
        cmp(flags, 8'h00);
        cmd(8'h10);
        cmp(flags, 8'h02);
        cmd(8'h11);
    endtask
    task automatic t_stby;
        cmd(8'h04);
        cmp(flags, 8'h08);
        cmd(8'h08);
        cmd(8'h1A);
        cmp(flags, 8'h08);
        cmd(8'h02);
        cmp(win_q, 8'h84);
        cmp(flags, 8'h00);
    endtask
    task automatic t_conv;
        cmd(8'h08);
        cmd(8'h08);
        cmp(flags, 8'h04);
        cmd(8'h0A);
        cmp(flags, 8'h04);
        pulse;
        cmd(8'h0A);
        cmp(flags, 8'h00);
        cmd(8'h1A);
        cmp(win_q & 8'h7F, 8'h46);
        cmd(8'h06);
        cmp(win_q & 8'h80, 8'h80);
        cmp({5'h0, rate_select}, 8'h04);
    endtask
    // Cuts a hung run short.
    initial begin
        #200000;
        err_count++;
        stop_test;
    end
    // Reset for four cycles, then the scenarios in turn.
    initial begin
        for (int i = 0; i < 27; i++) frame_data[8*i +: 8] = 8'(i * 37 + 5);
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        cmp(flags, 8'h02);
        cmp({dout, sample_ready_n, busy, reg_wr_valid, 1'b0, rate_select}, 8'h44);
        t_frame;
        t_store(1'b0);
        t_leave;
        t_store(1'b1);
        t_stby;
        t_conv;
        stop_test;
    end
endmodule
